// File: design/dma_chan_pkg.sv
// Constants, types and register map of the DMA channel register block.
`default_nettype none
package dma_chan_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] IDX_SRC = 3'h0;
  localparam logic [2:0] IDX_DST = 3'h1;
  localparam logic [2:0] IDX_CNT = 3'h2;
  localparam logic [2:0] IDX_BLK = 3'h3;
  localparam logic [2:0] IDX_OFS = 3'h4;
  localparam logic [2:0] IDX_MODE = 3'h5;
  localparam logic [2:0] IDX_ACTL = 3'h6;
  localparam int MIN_AXI_ADDR_W = 5;
  // ****************************************
  // Mode register fields
  // ****************************************
  localparam int MD_ENABLE = 0;
  localparam int MD_BUSY = 1;
  localparam int MD_FAULT = 2;
  localparam int MD_ESCAPE = 3;
  localparam int MD_CNTEND = 4;
  localparam int MD_ESC_IE = 5;
  localparam int MD_CNT_IE = 6;
  localparam int MD_SIZE = 8;
  localparam int MD_XMODE = 10;
  // ****************************************
  // Address control register fields
  // ****************************************
  localparam int AC_SRC_STEP = 0;
  localparam int AC_DST_STEP = 2;
  localparam int AC_AREA_DST = 4;
  localparam int AC_RPT_IE = 5;
  localparam int AC_SRC_EXT = 6;
  localparam int AC_DST_EXT = 11;
  localparam int AC_SRC_EXT_IE = 16;
  localparam int AC_DST_EXT_IE = 17;
  localparam int AC_WIDTH = 18;
  // ****************************************
  // Reset values and responses
  // ****************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_WAIT = 2'h1, ST_READ = 2'h3, ST_WRITE = 2'h2
  } state_e;
  typedef enum logic [1:0] {
    STEP_FIX = 2'h0, STEP_OFS = 2'h1, STEP_INC = 2'h2, STEP_DEC = 2'h3
  } step_e;
  typedef enum logic [1:0] {
    XM_NORMAL = 2'h0, XM_BURST = 2'h1, XM_BLOCK = 2'h2, XM_REPEAT = 2'h3
  } xmode_e;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } size_e;
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] bytes;
    logic write;
  } bus_cmd_s;
endpackage
`default_nettype wire

// File: design/addr_stepper.sv
// Next-address calculation with extended repeat area masking.
`timescale 1ns/1ps
`default_nettype none
module addr_stepper (
  input wire logic [31:0] base,
  input wire logic [1:0] mode,
  input wire logic [2:0] unitBytes,
  input wire logic [31:0] offset,
  input wire logic [4:0] extBits,
  output logic [31:0] nextAddr,
  output logic overflow
);
  logic [31:0] raw;
  logic [31:0] keepMask;
  logic [31:0] stepVal;

  assign stepVal = {29'h0, unitBytes};
  always_comb begin
    case (mode)
      dma_chan_pkg::STEP_OFS: raw = base + offset;
      dma_chan_pkg::STEP_INC: raw = base + stepVal;
      dma_chan_pkg::STEP_DEC: raw = base - stepVal;
      default: raw = base;
    endcase
  end
  // Bits above the area size stay put; zero size means no area.
  assign keepMask = (extBits == 5'h0) ? 32'h0 :
                    ~((32'h1 << extBits) - 32'h1);
  assign nextAddr = (base & keepMask) | (raw & ~keepMask);
  assign overflow = (extBits != 5'h0) &&
                    ((raw & keepMask) != (base & keepMask));
endmodule
`default_nettype wire

// File: design/block_counter.sv
// Block size counter step with reload from the constant upper half.
`timescale 1ns/1ps
`default_nettype none
module block_counter (
  input wire logic [31:0] blockSize,
  output logic [31:0] nextBlockSize,
  output logic wrap
);
  assign wrap = blockSize[15:0] == 16'h0001;
  assign nextBlockSize = wrap ? {blockSize[31:16], blockSize[31:16]} :
    {blockSize[31:16], blockSize[15:0] - 16'h0001};
endmodule
`default_nettype wire

// File: design/dma_channel_regs.sv
// DMA channel registers with AXI4-Lite access and transfer updates.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_regs #(
  parameter int AXI_ADDR_W = 5,
  parameter bit IS_FIRST_CHANNEL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic xferReq,
  input wire logic faultEvent,
  input wire logic standby,
  output logic busValid,
  output dma_chan_pkg::bus_cmd_s busCmd,
  input wire logic busAck,
  output logic transferEnable,
  output logic channelBusy,
  output logic escapeIrq,
  output logic countEndIrq
);
  if (AXI_ADDR_W < dma_chan_pkg::MIN_AXI_ADDR_W) begin : g_chk
    $error("AXI_ADDR_W too small for the register map.");
  end

  // ****************************************
  // Register state
  // ****************************************
  logic hardClr, faultFlag, escapeFlag, countEndFlag;
  logic escapeIrqEn, countEndIrqEn;
  logic [31:0] srcAddrReg, dstAddrReg, byteCountReg, blockSizeReg;
  logic [31:0] offsetReg, modeWord;
  logic [dma_chan_pkg::AC_WIDTH-1:0] addrCtrlReg;
  logic [1:0] accessSizeSel, xferMode;

  // Hardware standby clears the channel registers just as reset does; the AXI4-Lite slave is cleared by rst only.
  assign hardClr = rst || standby;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic awHeld, wHeld, awMapped, doWrite, arMapped;
  logic [2:0] awIdx, arIdx;
  logic [3:0] wStrbQ;
  logic [31:0] wDataQ, readMux;

  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign arready = !rvalid;
  assign doWrite = awHeld && wHeld;
  assign arIdx = araddr[4:2];
  assign arMapped = (araddr[AXI_ADDR_W-1:2] <= (AXI_ADDR_W-2)'(6));

  always_ff @(posedge mclk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awIdx <= 3'h0;
      awMapped <= 1'b0;
      wDataQ <= dma_chan_pkg::RST_WORD;
      wStrbQ <= 4'h0;
      bvalid <= 1'b0;
      bresp <= dma_chan_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awIdx <= awaddr[4:2];
        awMapped <= awaddr[AXI_ADDR_W-1:2] <= (AXI_ADDR_W-2)'(6);
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= awMapped ? dma_chan_pkg::RESP_OKAY :
                            dma_chan_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= dma_chan_pkg::RST_WORD;
      rresp <= dma_chan_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= arMapped ? readMux : dma_chan_pkg::RST_WORD;
      rresp <= arMapped ? dma_chan_pkg::RESP_OKAY :
                          dma_chan_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Write strobes per register.
  logic wrSrc, wrDst, wrCnt, wrBlk, wrOfs, wrMode, wrActl;
  logic [31:0] modeMerged;
  logic [31:0] actlMerged;
  assign wrSrc = doWrite && awMapped && awIdx == dma_chan_pkg::IDX_SRC;
  assign wrDst = doWrite && awMapped && awIdx == dma_chan_pkg::IDX_DST;
  assign wrCnt = doWrite && awMapped && awIdx == dma_chan_pkg::IDX_CNT;
  assign wrBlk = doWrite && awMapped && awIdx == dma_chan_pkg::IDX_BLK;
  assign wrOfs = doWrite && awMapped && awIdx == dma_chan_pkg::IDX_OFS;
  assign wrMode = doWrite && awMapped && awIdx == dma_chan_pkg::IDX_MODE;
  assign wrActl = doWrite && awMapped && awIdx == dma_chan_pkg::IDX_ACTL;
  assign modeMerged = merge(modeWord, wDataQ, wStrbQ);
  assign actlMerged = merge(32'(addrCtrlReg), wDataQ, wStrbQ);

  always_comb begin
    modeWord = dma_chan_pkg::RST_WORD;
    modeWord[dma_chan_pkg::MD_ENABLE] = transferEnable;
    modeWord[dma_chan_pkg::MD_BUSY] = channelBusy;
    modeWord[dma_chan_pkg::MD_FAULT] = faultFlag;
    modeWord[dma_chan_pkg::MD_ESCAPE] = escapeFlag;
    modeWord[dma_chan_pkg::MD_CNTEND] = countEndFlag;
    modeWord[dma_chan_pkg::MD_ESC_IE] = escapeIrqEn;
    modeWord[dma_chan_pkg::MD_CNT_IE] = countEndIrqEn;
    modeWord[dma_chan_pkg::MD_SIZE +: 2] = accessSizeSel;
    modeWord[dma_chan_pkg::MD_XMODE +: 2] = xferMode;
  end

  always_comb begin
    case (arIdx)
      dma_chan_pkg::IDX_SRC: readMux = srcAddrReg;
      dma_chan_pkg::IDX_DST: readMux = dstAddrReg;
      dma_chan_pkg::IDX_CNT: readMux = byteCountReg;
      dma_chan_pkg::IDX_BLK: readMux = blockSizeReg;
      dma_chan_pkg::IDX_OFS: readMux = offsetReg;
      dma_chan_pkg::IDX_MODE: readMux = modeWord;
      dma_chan_pkg::IDX_ACTL: readMux = 32'(addrCtrlReg);
      default: readMux = dma_chan_pkg::RST_WORD;
    endcase
  end

  // ****************************************
  // Transfer sequencing
  // ****************************************
  dma_chan_pkg::state_e state, nextState;
  logic [2:0] unitBytes, remain, pieceBytes;
  logic [31:0] curAddr, startSrc, startDst, srcOrigin, dstOrigin;
  logic [31:0] srcNext, dstNext, blkNext;
  logic srcOvf, dstOvf, srcOvfQ, blkWrap, blockActive;
  logic ack, lastPiece, unitDone, wrapNow, cntHits;
  logic countEnd, extStop, escapeStop, dmaStop, reenable, modeEnBit;

  always_comb begin
    case (accessSizeSel)
      dma_chan_pkg::SZ_WORD: unitBytes = 3'h2;
      dma_chan_pkg::SZ_LONG: unitBytes = 3'h4;
      default: unitBytes = 3'h1;
    endcase
  end

  // Misaligned units go out as the largest aligned piece that fits.
  assign curAddr = (state == dma_chan_pkg::ST_WRITE) ? dstAddrReg :
                                                       srcAddrReg;
  assign pieceBytes = (remain >= 3'h4 && curAddr[1:0] == 2'h0) ? 3'h4 :
                      (remain >= 3'h2 && !curAddr[0]) ? 3'h2 :
                      3'h1;
  assign lastPiece = pieceBytes == remain;
  assign busValid = state == dma_chan_pkg::ST_READ ||
                    state == dma_chan_pkg::ST_WRITE;
  assign busCmd = '{addr: curAddr, bytes: pieceBytes,
                    write: state == dma_chan_pkg::ST_WRITE};
  assign ack = busValid && busAck;
  assign unitDone = ack && lastPiece &&
                    state == dma_chan_pkg::ST_WRITE;

  addr_stepper u_src_step (
    .base(startSrc),
    .mode(addrCtrlReg[dma_chan_pkg::AC_SRC_STEP +: 2]),
    .unitBytes(unitBytes),
    .offset(offsetReg),
    .extBits(addrCtrlReg[dma_chan_pkg::AC_SRC_EXT +: 5]),
    .nextAddr(srcNext),
    .overflow(srcOvf)
  );
  addr_stepper u_dst_step (
    .base(startDst),
    .mode(addrCtrlReg[dma_chan_pkg::AC_DST_STEP +: 2]),
    .unitBytes(unitBytes),
    .offset(offsetReg),
    .extBits(addrCtrlReg[dma_chan_pkg::AC_DST_EXT +: 5]),
    .nextAddr(dstNext),
    .overflow(dstOvf)
  );
  block_counter u_blk (
    .blockSize(blockSizeReg),
    .nextBlockSize(blkNext),
    .wrap(blkWrap)
  );

  assign blockActive = xferMode == dma_chan_pkg::XM_BLOCK ||
                       xferMode == dma_chan_pkg::XM_REPEAT;
  assign wrapNow = unitDone && blockActive && blkWrap;
  assign cntHits = byteCountReg != 32'h0 &&
                   byteCountReg == {29'h0, unitBytes};
  assign countEnd = unitDone && cntHits;
  // In block mode only an area overflow on the block's last unit stops the transfer.
  assign extStop = unitDone &&
    ((srcOvfQ && addrCtrlReg[dma_chan_pkg::AC_SRC_EXT_IE]) ||
     (dstOvf && addrCtrlReg[dma_chan_pkg::AC_DST_EXT_IE])) &&
    (xferMode != dma_chan_pkg::XM_BLOCK || blkWrap);
  assign escapeStop = extStop || (wrapNow &&
    xferMode == dma_chan_pkg::XM_REPEAT &&
    addrCtrlReg[dma_chan_pkg::AC_RPT_IE]);
  assign dmaStop = countEnd || escapeStop;
  assign modeEnBit = wDataQ[dma_chan_pkg::MD_ENABLE];
  assign reenable = wrMode && wStrbQ[0] && modeEnBit && !transferEnable;

  always_comb begin
    nextState = state;
    case (state)
      dma_chan_pkg::ST_IDLE: begin
        if (transferEnable) begin
          nextState = dma_chan_pkg::ST_WAIT;
        end
      end
      dma_chan_pkg::ST_WAIT: begin
        if (!transferEnable) begin
          nextState = dma_chan_pkg::ST_IDLE;
        end else if (xferReq) begin
          nextState = dma_chan_pkg::ST_READ;
        end
      end
      dma_chan_pkg::ST_READ: begin
        if (ack && lastPiece) begin
          nextState = dma_chan_pkg::ST_WRITE;
        end
      end
      dma_chan_pkg::ST_WRITE: begin
        if (unitDone) begin
          if (dmaStop) begin
            nextState = dma_chan_pkg::ST_IDLE;
          end else if (xferMode == dma_chan_pkg::XM_BLOCK && !blkWrap) begin
            nextState = dma_chan_pkg::ST_READ;
          end else if (!transferEnable) begin
            nextState = dma_chan_pkg::ST_IDLE;
          end else if (xferMode == dma_chan_pkg::XM_BURST) begin
            nextState = dma_chan_pkg::ST_READ;
          end else begin
            nextState = dma_chan_pkg::ST_WAIT;
          end
        end
      end
      default: nextState = dma_chan_pkg::ST_IDLE;
    endcase
    if (faultEvent) begin
      nextState = dma_chan_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (hardClr) begin
      state <= dma_chan_pkg::ST_IDLE;
      remain <= 3'h0;
      startSrc <= dma_chan_pkg::RST_WORD;
      startDst <= dma_chan_pkg::RST_WORD;
      srcOvfQ <= 1'b0;
    end else begin
      state <= nextState;
      if (nextState == dma_chan_pkg::ST_READ &&
          state != dma_chan_pkg::ST_READ) begin
        remain <= unitBytes;
        startSrc <= srcAddrReg;
      end else if (nextState == dma_chan_pkg::ST_WRITE &&
                   state != dma_chan_pkg::ST_WRITE) begin
        remain <= unitBytes;
        startDst <= dstAddrReg;
        srcOvfQ <= srcOvf;
      end else if (ack) begin
        remain <= remain - pieceBytes;
      end
    end
  end

  // ****************************************
  // Address, count and block registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (hardClr) begin
      srcAddrReg <= dma_chan_pkg::RST_WORD;
      dstAddrReg <= dma_chan_pkg::RST_WORD;
    end else begin
      if (wrSrc) begin
        srcAddrReg <= merge(srcAddrReg, wDataQ, wStrbQ);
      end else if (wrapNow && !addrCtrlReg[dma_chan_pkg::AC_AREA_DST]) begin
        srcAddrReg <= srcOrigin;
      end else if (ack && state == dma_chan_pkg::ST_READ) begin
        srcAddrReg <= lastPiece ? srcNext :
                      srcAddrReg + {29'h0, pieceBytes};
      end
      if (wrDst) begin
        dstAddrReg <= merge(dstAddrReg, wDataQ, wStrbQ);
      end else if (wrapNow && addrCtrlReg[dma_chan_pkg::AC_AREA_DST]) begin
        dstAddrReg <= dstOrigin;
      end else if (ack && state == dma_chan_pkg::ST_WRITE) begin
        dstAddrReg <= lastPiece ? dstNext :
                      dstAddrReg + {29'h0, pieceBytes};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (hardClr) begin
      byteCountReg <= dma_chan_pkg::RST_WORD;
      blockSizeReg <= dma_chan_pkg::RST_WORD;
      offsetReg <= dma_chan_pkg::RST_WORD;
      addrCtrlReg <= '0;
      srcOrigin <= dma_chan_pkg::RST_WORD;
      dstOrigin <= dma_chan_pkg::RST_WORD;
    end else begin
      if (wrCnt) begin
        byteCountReg <= merge(byteCountReg, wDataQ, wStrbQ);
      end else if (unitDone && byteCountReg != 32'h0) begin
        byteCountReg <= byteCountReg - {29'h0, unitBytes};
      end
      if (wrBlk) begin
        blockSizeReg <= merge(blockSizeReg, wDataQ, wStrbQ);
      end else if (unitDone && blockActive) begin
        blockSizeReg <= blkNext;
      end
      if (wrOfs) begin
        offsetReg <= merge(offsetReg, wDataQ, wStrbQ);
      end
      if (wrActl) begin
        addrCtrlReg <= actlMerged[dma_chan_pkg::AC_WIDTH-1:0];
      end
      if (reenable) begin
        srcOrigin <= srcAddrReg;
        dstOrigin <= dstAddrReg;
      end
    end
  end

  // ****************************************
  // Mode register
  // ****************************************
  always_ff @(posedge mclk) begin
    if (hardClr) begin
      transferEnable <= 1'b0;
      faultFlag <= 1'b0;
      escapeFlag <= 1'b0;
      countEndFlag <= 1'b0;
      escapeIrqEn <= 1'b0;
      countEndIrqEn <= 1'b0;
      accessSizeSel <= 2'h0;
      xferMode <= 2'h0;
    end else begin
      if (faultEvent || dmaStop) begin
        transferEnable <= 1'b0;
      end else if (wrMode && wStrbQ[0]) begin
        transferEnable <= modeEnBit;
      end
      if (faultEvent && IS_FIRST_CHANNEL) begin
        faultFlag <= 1'b1;
      end else if (wrMode && wStrbQ[0] &&
                   !wDataQ[dma_chan_pkg::MD_FAULT]) begin
        faultFlag <= 1'b0;
      end
      // A setting event wins over the clear by re-enabling.
      escapeFlag <= escapeStop || (escapeFlag && !reenable);
      countEndFlag <= countEnd || (countEndFlag && !reenable);
      if (wrMode) begin
        escapeIrqEn <= modeMerged[dma_chan_pkg::MD_ESC_IE];
        countEndIrqEn <= modeMerged[dma_chan_pkg::MD_CNT_IE];
        accessSizeSel <= modeMerged[dma_chan_pkg::MD_SIZE +: 2];
        xferMode <= modeMerged[dma_chan_pkg::MD_XMODE +: 2];
      end
    end
  end

  assign channelBusy = busValid;
  assign escapeIrq = escapeFlag && escapeIrqEn;
  assign countEndIrq = countEndFlag && countEndIrqEn;

  logic unusedProt;
  assign unusedProt = ^{awprot, arprot};
endmodule
`default_nettype wire

// File: sim/dma_chan_assertions.sv
// Concurrent checks on the ports of the DMA channel register block.
`timescale 1ns/1ps
`default_nettype none
module dma_chan_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic standby,
  input wire logic faultEvent,
  input wire logic busValid,
  input wire dma_chan_pkg::bus_cmd_s busCmd,
  input wire logic busAck,
  input wire logic transferEnable,
  input wire logic channelBusy,
  input wire logic countEndIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  busy_idle_a:
    assert property (!transferEnable && !channelBusy |=> !channelBusy)
    else $error("Busy flag rose while the channel was disabled.");
  cmd_held_a:
    assert property (busValid && !busAck |=> busValid && $stable(busCmd))
    else $error("Bus piece changed before it was acknowledged.");
  piece_size_a:
    assert property (busValid |-> busCmd.bytes inside {3'h1, 3'h2, 3'h4})
    else $error("Bus piece has an illegal byte count.");
  piece_align_a:
    assert property (busValid |-> (busCmd.addr[2:0] & (busCmd.bytes - 3'h1)) == 3'h0)
    else $error("Bus piece is not aligned to its size.");
  fault_stop_a:
    assert property (faultEvent |=> !transferEnable)
    else $error("Enable survived a fault event.");
  standby_stop_a:
    assert property (standby |=> !transferEnable && !busValid && !countEndIrq)
    else $error("Channel state survived standby.");
  start_needs_en_a:
    assert property ($rose(busValid) |-> $past(transferEnable))
    else $error("Transfer started while disabled.");
  cnt_end_stop_a:
    assert property ($rose(countEndIrq) |-> !transferEnable)
    else $error("Count end flagged while still enabled.");
endmodule
bind dma_channel_regs dma_chan_assertions chk_u (.mclk(mclk), .rst(rst),
  .standby(standby), .faultEvent(faultEvent), .busValid(busValid),
  .busCmd(busCmd), .busAck(busAck), .transferEnable(transferEnable),
  .channelBusy(channelBusy), .countEndIrq(countEndIrq));
`default_nettype wire

// File: sim/bus_partner.sv
// System bus model that acknowledges each piece promptly or after a stall.
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  input wire logic mclk,
  input wire logic rst,
  input wire logic busValid,
  input wire logic slow,
  output logic busAck
);
  logic [1:0] waitCnt;
  always_ff @(posedge mclk) begin
    if (rst || !busValid || busAck) begin
      waitCnt <= 2'h0;
    end else begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
  // A slow bus holds each piece for two extra cycles.
  assign busAck = busValid && (!slow || waitCnt == 2'h2);
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking testbench for the DMA channel register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, rst, awvalid, wvalid, arvalid, xferReq, faultEvent, standby;
  logic slow, awready, wready, bvalid, arready, rvalid, busValid, busAck;
  logic transferEnable, channelBusy, escapeIrq, countEndIrq;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, rr;
  dma_chan_pkg::bus_cmd_s busCmd;
  dma_chan_pkg::bus_cmd_s log[$];
  int nMismatch, comparisons, cyc;
  dma_channel_regs dut_u (.mclk(mclk), .rst(rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(1'b1), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(1'b1),
    .rdata(rdata), .rresp(rresp), .xferReq(xferReq),
    .faultEvent(faultEvent), .standby(standby), .busValid(busValid),
    .busCmd(busCmd), .busAck(busAck), .transferEnable(transferEnable),
    .channelBusy(channelBusy), .escapeIrq(escapeIrq),
    .countEndIrq(countEndIrq));
  bus_partner partner_u (.mclk(mclk), .rst(rst), .busValid(busValid),
    .slow(slow), .busAck(busAck));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (busValid && busAck) log.push_back(busCmd);
    cyc++;
    if (cyc == 5000) begin
      nMismatch++;
      close_out();
    end
  end
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, e);
  endtask
  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rv = rdata;
    rr = rresp;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic prog(input logic [31:0] v [7]);
    log.delete();
    for (int i = 0; i < 7; i++) begin
      if (i != 5) wr(5'(i * 4), v[i], dma_chan_pkg::RESP_OKAY);
    end
    wr(5'h14, v[5], dma_chan_pkg::RESP_OKAY);
  endtask
  task automatic waitn(input int n);
    while (log.size() < n) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic pc(input int i, input logic [31:0] a, input logic [2:0] b,
                    input logic w);
    chk(log[i], {a, b, w});
  endtask
  task automatic regs_check();
    rchk(5'h14, 32'h0);
    wr(5'h10, 32'hfffe_0001, dma_chan_pkg::RESP_OKAY);
    rchk(5'h10, 32'hfffe_0001);
    wr(5'h1c, 32'h1, dma_chan_pkg::RESP_SLVERR);
    rchk(5'h1c, 32'h0);
    chk(rr, dma_chan_pkg::RESP_SLVERR);
  endtask
  task automatic word_xfer();
    prog('{32'h100, 32'h200, 32'h4, 32'h0, 32'h0, 32'h541, 32'he});
    xferReq <= 1'b1;
    waitn(4);
    xferReq <= 1'b0;
    pc(0, 32'h100, 3'h2, 1'b0);
    pc(1, 32'h200, 3'h2, 1'b1);
    pc(2, 32'h102, 3'h2, 1'b0);
    pc(3, 32'h1fe, 3'h2, 1'b1);
    rchk(5'h00, 32'h104);
    rchk(5'h04, 32'h1fc);
    rchk(5'h08, 32'h0);
    rchk(5'h14, 32'h550);
    chk(countEndIrq, 1'b1);
  endtask
  task automatic split_xfer();
    slow <= 1'b1;
    prog('{32'h301, 32'h400, 32'h4, 32'h0, 32'h10, 32'h201, 32'h6});
    xferReq <= 1'b1;
    waitn(4);
    xferReq <= 1'b0;
    slow <= 1'b0;
    pc(0, 32'h301, 3'h1, 1'b0);
    pc(1, 32'h302, 3'h2, 1'b0);
    pc(2, 32'h304, 3'h1, 1'b0);
    pc(3, 32'h400, 3'h4, 1'b1);
    rchk(5'h00, 32'h305);
    rchk(5'h04, 32'h410);
  endtask
  task automatic block_xfer();
    prog('{32'h500, 32'h600, 32'h0, 32'h2_0002, 32'h0, 32'h801, 32'h2});
    xferReq <= 1'b1;
    while (log.size() < 1) @(posedge mclk);
    xferReq <= 1'b0;
    waitn(4);
    pc(2, 32'h501, 3'h1, 1'b0);
    pc(3, 32'h600, 3'h1, 1'b1);
    rchk(5'h00, 32'h500);
    rchk(5'h0c, 32'h2_0002);
    rchk(5'h08, 32'h0);
    wr(5'h14, 32'h800, dma_chan_pkg::RESP_OKAY);
    rchk(5'h14, 32'h800);
    chk(channelBusy, 1'b0);
  endtask
  task automatic repeat_xfer();
    prog('{32'h700, 32'h803, 32'h0, 32'h1_0001, 32'h0, 32'hd21, 32'h7a});
    xferReq <= 1'b1;
    waitn(3);
    xferReq <= 1'b0;
    pc(0, 32'h700, 3'h2, 1'b0);
    pc(1, 32'h803, 3'h1, 1'b1);
    pc(2, 32'h804, 3'h1, 1'b1);
    rchk(5'h00, 32'h700);
    rchk(5'h04, 32'h803);
    rchk(5'h14, 32'hd28);
    chk(escapeIrq, 1'b1);
  endtask
  task automatic fault_stop();
    wr(5'h14, 32'h1, dma_chan_pkg::RESP_OKAY);
    faultEvent <= 1'b1;
    @(posedge mclk);
    faultEvent <= 1'b0;
    rchk(5'h14, 32'h4);
    standby <= 1'b1;
    @(posedge mclk);
    standby <= 1'b0;
    rchk(5'h14, 32'h0);
  endtask
  task automatic close_out();
    if (nMismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, arvalid, xferReq, faultEvent, standby, slow} = 7'h0;
    awaddr = 5'h0;
    araddr = 5'h0;
    wdata = 32'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    regs_check();
    word_xfer();
    split_xfer();
    block_xfer();
    repeat_xfer();
    fault_stop();
    close_out();
  end
endmodule
`default_nettype wire
